// file: logic/vic_consts.svh
// Offsets, field positions and reset values of the vectored interrupt block.
// Assumes inclusion from the design module, the checker and the bench by bare name.
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// Register byte addresses on the AXI4-Lite bus.
`define VIC_OFF_CMD      8'h00
`define VIC_OFF_DATA     8'h04
`define VIC_OFF_ACK      8'h08
`define VIC_OFF_STATUS   8'h0c

// Command word and mode word field positions.
`define VIC_W1_START     4
`define VIC_W1_LEVEL     3
`define VIC_W1_SPACING   2
`define VIC_W1_SINGLE    1
`define VIC_W1_NEED4     0
`define VIC_OP3_SEL      3
`define VIC_MODE_AEOS    1
`define VIC_MODE_NEST    4
`define VIC_OP2_ROT      7
`define VIC_OP2_SPEC     6
`define VIC_OP2_EOS      5
`define VIC_OP3_SPECIAL_MASKING_ENABLE     6
`define VIC_OP3_SMM      5
`define VIC_OP3_POLL     2
`define VIC_OP3_RDEN     1
`define VIC_OP3_RDSEL    0

// Reset values and bus response codes.
`define VIC_MASK_RST     8'hff
`define VIC_PRIO_RST     3'h7
`define VIC_RESP_OKAY    2'h0
`define VIC_RESP_SLVERR  2'h2

`endif

// file: logic/vic_pkg.sv
// Types shared by the vectored interrupt command block.
// Assumes the constants header sits beside it.
package vic_pkg;
    typedef enum logic [3:0] {
        VIC_ST_READY = 4'h1,
        VIC_ST_VEC   = 4'h2,
        VIC_ST_CASC  = 4'h4,
        VIC_ST_MODE  = 4'h8
    } vic_init_t;
endpackage

// file: logic/vic_cmd_prog.sv
// Command-word programming and priority logic of an eight-input vectored
// interrupt controller, reached over AXI4-Lite with 32-bit data.
// Assumes one 10 MHz clock; request inputs are asynchronous pins.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"

module vic_cmd_prog
    import vic_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Request pins and interrupt output
    input  wire logic [7:0]  request_input,
    output var  logic        irq_out
);

    // Rank of a level below the lowest-priority level; zero is best.
    function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] base);
        rank = 3'(lvl - base - 3'd1);
    endfunction

    // Best-priority set bit, valid flag on top.
    function automatic logic [3:0] top(input logic [7:0] bits, input logic [2:0] base);
        logic [2:0] lv;
        top = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            lv = 3'(base + 3'(i) + 3'd1);
            if (bits[lv])
                top = {1'b1, lv};
        end
    endfunction

    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  wr_addr_r;
    logic [7:0]  wr_data_r;
    logic        wr_lane_r;
    logic        wr_fire;
    logic        rd_take;
    logic [31:0] rd_word;
    logic        rd_ok;

    vic_init_t   state_r;
    logic        single_r;
    logic        need4_r;
    logic        spacing_r;
    logic        level_trig_r;
    logic [2:0]  vec_low_r;
    logic [7:0]  vec_base_r;
    logic [7:0]  slave_map_r;
    logic        aeos_r;
    logic        nest_r;
    logic [7:0]  mode_r;
    logic        smm_r;
    logic        rot_aeos_r;
    logic        rd_isr_r;
    logic        poll_r;

    logic [7:0]  req_s1_r;
    logic [7:0]  req_s2_r;
    logic [7:0]  arm_r;
    logic [7:0]  pend_r;
    logic [7:0]  isr_r;
    logic [7:0]  mask_r;
    logic [2:0]  prio_r;
    logic [16:0] vec_r;

    logic        wr_cmd;
    logic        wr_data;
    logic        init_wr;
    logic        op2_wr;
    logic        op3_wr;
    logic        ready;
    logic [7:0]  blk_isr;
    logic [3:0]  cand;
    logic [3:0]  isr_top;
    logic [3:0]  blk_top;
    logic        cand_ok;
    logic        poll_rd;
    logic        ack;
    logic [15:0] vec_addr;

    // Write channel: address and data taken in either order.
    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            wr_addr_r     <= 8'h00;
            wr_data_r     <= 8'h00;
            wr_lane_r     <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r      <= 1'b1;
                wr_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            else if (!aw_got_r && !s_axi_bvalid)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r      <= 1'b1;
                wr_data_r    <= s_axi_wdata[7:0];
                wr_lane_r    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            else if (!w_got_r && !s_axi_bvalid)
                s_axi_wready <= 1'b1;
            if (wr_fire)
            begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `VIC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            if (wr_addr_r == `VIC_OFF_CMD || wr_addr_r == `VIC_OFF_DATA ||
                wr_addr_r == `VIC_OFF_ACK || wr_addr_r == `VIC_OFF_STATUS)
                s_axi_bresp <= `VIC_RESP_OKAY;
            else
                s_axi_bresp <= `VIC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Command decode; only byte lane 0 carries a command word.
    assign wr_cmd  = wr_fire && wr_lane_r && wr_addr_r == `VIC_OFF_CMD;
    assign wr_data = wr_fire && wr_lane_r && wr_addr_r == `VIC_OFF_DATA;
    assign init_wr = wr_cmd && wr_data_r[`VIC_W1_START];
    assign op3_wr  = wr_cmd && !wr_data_r[`VIC_W1_START] && wr_data_r[`VIC_OP3_SEL] && ready;
    assign op2_wr  = wr_cmd && !wr_data_r[`VIC_W1_START] && !wr_data_r[`VIC_OP3_SEL] && ready;
    assign ready   = state_r == VIC_ST_READY;

    // Initialization sequencer and mode state.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r      <= VIC_ST_READY;
            single_r     <= 1'b1;
            need4_r      <= 1'b0;
            spacing_r    <= 1'b0;
            level_trig_r <= 1'b0;
            vec_low_r    <= 3'h0;
            vec_base_r   <= 8'h00;
            slave_map_r  <= 8'h00;
            mode_r       <= 8'h00;
        end
        else if (init_wr)
        begin
            state_r      <= VIC_ST_VEC;
            single_r     <= wr_data_r[`VIC_W1_SINGLE];
            need4_r      <= wr_data_r[`VIC_W1_NEED4];
            spacing_r    <= wr_data_r[`VIC_W1_SPACING];
            level_trig_r <= wr_data_r[`VIC_W1_LEVEL];
            vec_low_r    <= wr_data_r[7:5];
            if (!wr_data_r[`VIC_W1_NEED4])
                mode_r <= 8'h00;
        end
        else if (wr_data)
        begin
            case (state_r)
                VIC_ST_VEC:
                begin
                    vec_base_r <= wr_data_r;
                    if (!single_r)
                        state_r <= VIC_ST_CASC;
                    else if (need4_r)
                        state_r <= VIC_ST_MODE;
                    else
                        state_r <= VIC_ST_READY;
                end
                VIC_ST_CASC:
                begin
                    slave_map_r <= wr_data_r;
                    state_r     <= need4_r ? VIC_ST_MODE : VIC_ST_READY;
                end
                VIC_ST_MODE:
                begin
                    mode_r  <= wr_data_r;
                    state_r <= VIC_ST_READY;
                end
                default:
                    state_r <= state_r;
            endcase
        end
    end

    assign aeos_r = mode_r[`VIC_MODE_AEOS];
    assign nest_r = mode_r[`VIC_MODE_NEST];

    // Third operation word state; a poll read ends polling mode.
    always_ff @(posedge clk)
    begin
        if (!rst_n || init_wr)
        begin
            smm_r    <= 1'b0;
            rd_isr_r <= 1'b0;
            poll_r   <= 1'b0;
        end
        else if (op3_wr)
        begin
            if (wr_data_r[`VIC_OP3_SPECIAL_MASKING_ENABLE])
                smm_r <= wr_data_r[`VIC_OP3_SMM];
            if (wr_data_r[`VIC_OP3_RDEN])
                rd_isr_r <= wr_data_r[`VIC_OP3_RDSEL];
            poll_r <= wr_data_r[`VIC_OP3_POLL];
        end
        else if (poll_rd)
            poll_r <= 1'b0;
    end

    // Request pins pass two flip-flops before any logic reads them.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            req_s1_r <= 8'h00;
            req_s2_r <= 8'h00;
        end
        else
        begin
            req_s1_r <= request_input;
            req_s2_r <= req_s1_r;
        end
    end

    // Pending requests; the mask plays no part here, so masked edges wait.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            arm_r  <= 8'h00;
            pend_r <= 8'h00;
        end
        else if (init_wr)
        begin
            arm_r  <= 8'h00;
            pend_r <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (!req_s2_r[i])
                    arm_r[i] <= 1'b1;
                else if (arm_r[i])
                    arm_r[i] <= 1'b0;
                if (ack && cand_ok && cand[2:0] == 3'(i))
                    pend_r[i] <= 1'b0;
                else if (level_trig_r)
                    pend_r[i] <= req_s2_r[i];
                else if (req_s2_r[i] && arm_r[i])
                    pend_r[i] <= 1'b1;
            end
        end
    end

    // Priority resolution against the levels in service.
    always_comb
    begin
        blk_isr = isr_r;
        if (smm_r)
            blk_isr = isr_r & ~mask_r;
        if (nest_r && !single_r)
            blk_isr = blk_isr & ~slave_map_r;
    end

    assign cand    = top(pend_r & ~mask_r, prio_r);
    assign isr_top = top(isr_r, prio_r);
    assign blk_top = top(blk_isr, prio_r);
    assign cand_ok = ready && cand[3] && (!blk_top[3] ||
                     rank(cand[2:0], prio_r) < rank(blk_top[2:0], prio_r));
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign poll_rd = rd_take && s_axi_araddr == `VIC_OFF_CMD && poll_r;
    assign ack     = poll_rd || (wr_fire && wr_addr_r == `VIC_OFF_ACK);

    // Service bits, mask and rotation.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            isr_r      <= 8'h00;
            mask_r     <= `VIC_MASK_RST;
            prio_r     <= `VIC_PRIO_RST;
            rot_aeos_r <= 1'b0;
        end
        else if (init_wr)
        begin
            isr_r      <= 8'h00;
            mask_r     <= 8'h00;
            prio_r     <= `VIC_PRIO_RST;
            rot_aeos_r <= 1'b0;
        end
        else
        begin
            if (wr_data && ready)
                mask_r <= wr_data_r;
            if (ack && cand_ok)
            begin
                if (!aeos_r)
                    isr_r[cand[2:0]] <= 1'b1;
                else if (rot_aeos_r)
                    prio_r <= cand[2:0];
            end
            else if (op2_wr)
            begin
                case ({wr_data_r[`VIC_OP2_ROT], wr_data_r[`VIC_OP2_SPEC],
                       wr_data_r[`VIC_OP2_EOS]})
                    3'h1:
                        isr_r[isr_top[2:0]] <= 1'b0;
                    3'h3:
                        isr_r[wr_data_r[2:0]] <= 1'b0;
                    3'h5:
                    begin
                        isr_r[isr_top[2:0]] <= 1'b0;
                        if (isr_top[3])
                            prio_r <= isr_top[2:0];
                    end
                    3'h7:
                    begin
                        isr_r[wr_data_r[2:0]] <= 1'b0;
                        prio_r                <= wr_data_r[2:0];
                    end
                    3'h6:
                        prio_r <= wr_data_r[2:0];
                    3'h4:
                        rot_aeos_r <= 1'b1;
                    3'h0:
                        rot_aeos_r <= 1'b0;
                    default:
                        rot_aeos_r <= rot_aeos_r;
                endcase
            end
        end
    end

    // Vector address for the level being acknowledged.
    always_comb
    begin
        if (spacing_r)
            vec_addr = {vec_base_r, vec_low_r, cand[2:0], 2'b00};
        else
            vec_addr = {vec_base_r, vec_low_r[2:1], cand[2:0], 3'b000};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || init_wr)
        begin
            vec_r   <= 17'h0_0000;
            irq_out <= 1'b0;
        end
        else
        begin
            irq_out <= cand_ok && !poll_r && !ack;
            if (ack)
                vec_r <= {cand_ok, cand_ok ? vec_addr : 16'h0000};
        end
    end

    // Read data; the status word exposes sequencer and mode state.
    always_comb
    begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == `VIC_OFF_CMD)
        begin
            if (poll_r)
                rd_word = {24'h00_0000, cand_ok, 4'h0, cand[2:0]};
            else
                rd_word = {24'h00_0000, rd_isr_r ? isr_r : pend_r};
        end
        else if (s_axi_araddr == `VIC_OFF_DATA)
            rd_word = {24'h00_0000, mask_r};
        else if (s_axi_araddr == `VIC_OFF_ACK)
            rd_word = {15'h0000, vec_r};
        else if (s_axi_araddr == `VIC_OFF_STATUS)
            rd_word = {10'h000, mode_r, prio_r, rot_aeos_r, smm_r, poll_r, rd_isr_r,
                       level_trig_r, spacing_r, single_r, state_r};
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `VIC_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

endmodule
`default_nettype wire

// file: tb/vic_cmd_prog_assertions.sv
// Port checker of the vectored interrupt command block.
// Assumes binding to vic_cmd_prog and a host that offers address and data together.
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"
module vic_cmd_prog_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Interrupt
    input wire logic        irq_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // A write that splits its halves is not recognised here, so the host must pair them.
    wire take     = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire cmd_take = take && s_axi_awaddr == `VIC_OFF_CMD;

    resp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    data_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    read_turn_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    write_turn_a:
        assert property (take |=> !s_axi_awready ##[0:1] s_axi_bvalid)
        else $error("write answer late");
    wake_up_a:
        assert property ($rose(rst_n) |->
            !s_axi_bvalid && !s_axi_rvalid && !irq_out ##[1:2] s_axi_arready)
        else $error("outputs active after reset");
    ack_drop_a:
        assert property (take && s_axi_awaddr == `VIC_OFF_ACK |-> ##[2:3] !irq_out)
        else $error("interrupt held after acknowledge");
    poll_mute_a:
        assert property (cmd_take && s_axi_wdata[4:2] == 3'h3 |-> ##3 !irq_out [*3])
        else $error("interrupt raised while polling");
    init_mute_a:
        assert property (cmd_take && s_axi_wdata[4] |-> ##2 !irq_out [*3])
        else $error("interrupt raised during setup");
endmodule

bind vic_cmd_prog vic_cmd_prog_assertions chk (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out)
);
`default_nettype wire

// file: tb/vic_host_model.sv
// Host processor model that writes command words and reads status over AXI4-Lite.
// Assumes the block's slave ports; lag makes the host slow to accept answers.
`timescale 1ns/1ps
`default_nettype none
module vic_host_model (
    // Clock
    input  wire logic        clk,
    // Write channels
    output var  logic [7:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    // Read channels
    output var  logic [7:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready
);
    int lag = 0;

    initial
    begin
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0000_0000;
        s_axi_wstrb   = 4'hf;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        n = lag;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= (n == 0);
        forever
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                break;
            if (s_axi_bvalid)
                n = n - 1;
            if (n <= 0)
                s_axi_bready <= 1'b1;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge clk);
        n = lag;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (n == 0);
        forever
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                break;
            if (s_axi_rvalid)
                n = n - 1;
            if (n <= 0)
                s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/vic_cmd_prog_test.sv
// Self-checking bench of the vectored interrupt command block.
// Assumes the host model beside it and the checker bound to the block.
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"
`define VIC_CHK(nm, want, got) \
    begin \
        compares++; \
        if ((got) !== (want)) \
        begin \
            failures++; \
            $display("mismatch %s expected %h seen %h", nm, want, got); \
        end \
    end
module vic_cmd_prog_test;
    logic        clk;
    logic        rst_n;
    logic [7:0]  request_input;
    logic [1:0]  resp;
    logic [31:0] rdv;
    int          failures;
    int          compares;
    wire [31:0]  s_axi_wdata, s_axi_rdata;
    wire [7:0]   s_axi_awaddr, s_axi_araddr;
    wire [3:0]   s_axi_wstrb;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire         irq_out;

    vic_cmd_prog dut (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .request_input(request_input), .irq_out(irq_out)
    );

    vic_host_model host (
        .clk(clk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cmd(input logic [7:0] d);
        host.wr(`VIC_OFF_CMD, d, resp);
    endtask
    task automatic dat(input logic [7:0] d);
        host.wr(`VIC_OFF_DATA, d, resp);
    endtask
    task automatic get(input logic [7:0] a);
        host.rd(a, rdv);
    endtask
    // The synchroniser adds two cycles, so twenty is ample before giving up.
    task automatic irq_wait();
        int n;
        n = 0;
        while (irq_out !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic t_reset();
        get(`VIC_OFF_DATA);
        `VIC_CHK("mask", 8'hff, rdv[7:0])
        get(`VIC_OFF_CMD);
        `VIC_CHK("pending", 8'h00, rdv[7:0])
    endtask

    task automatic t_cascade();
        cmd(8'hf1);
        request_input <= 8'h40;
        repeat (6) @(posedge clk);
        `VIC_CHK("setup irq", 1'b0, irq_out)
        dat(8'h34);
        get(`VIC_OFF_STATUS);
        `VIC_CHK("cascade wait", 4'h4, rdv[3:0])
        dat(8'h00);
        dat(8'h0e);
        get(`VIC_OFF_STATUS);
        `VIC_CHK("mode", 12'h0e1, {rdv[21:14], rdv[3:0]})
        irq_wait();
        `VIC_CHK("irq", 1'b1, irq_out)
        host.wr(`VIC_OFF_ACK, 8'h00, resp);
        get(`VIC_OFF_ACK);
        `VIC_CHK("vector 8", 17'h1_34f0, rdv[16:0])
        cmd(8'h0b);
        get(`VIC_OFF_CMD);
        `VIC_CHK("auto eos", 8'h00, rdv[7:0])
        request_input <= 8'h44;
        repeat (6) @(posedge clk);
        cmd(8'h0c);
        repeat (2) @(posedge clk);
        `VIC_CHK("poll irq", 1'b0, irq_out)
        get(`VIC_OFF_CMD);
        `VIC_CHK("poll", 8'h82, rdv[7:0])
    endtask

    task automatic t_single();
        host.lag = 2;
        request_input <= 8'h00;
        cmd(8'h6b);
        cmd(8'h80);
        cmd(8'hc2);
        get(`VIC_OFF_STATUS);
        `VIC_CHK("op modes", 6'h17, {rdv[13:11], rdv[10:9], rdv[7]})
        host.lag = 0;
        cmd(8'hb6);
        get(`VIC_OFF_STATUS);
        `VIC_CHK("init state", 6'h32, {rdv[5:4], rdv[3:0]})
        get(`VIC_OFF_DATA);
        `VIC_CHK("mask clear", 8'h00, rdv[7:0])
        dat(8'h12);
        get(`VIC_OFF_STATUS);
        `VIC_CHK("ready", 4'h1, rdv[3:0])
        `VIC_CHK("read sel", 1'b0, rdv[7])
        `VIC_CHK("mask mode", 2'h0, rdv[10:9])
        `VIC_CHK("lowest", 3'h7, rdv[13:11])
        `VIC_CHK("mode word", 8'h00, rdv[21:14])
        request_input <= 8'h08;
        irq_wait();
        `VIC_CHK("irq", 1'b1, irq_out)
        get(`VIC_OFF_CMD);
        `VIC_CHK("pending", 8'h08, rdv[7:0])
        host.wr(`VIC_OFF_ACK, 8'h00, resp);
        get(`VIC_OFF_ACK);
        `VIC_CHK("vector 4", 17'h1_12ac, rdv[16:0])
        cmd(8'h0b);
        get(`VIC_OFF_CMD);
        `VIC_CHK("service", 8'h08, rdv[7:0])
        cmd(8'h0a);
        get(`VIC_OFF_CMD);
        `VIC_CHK("acked", 8'h00, rdv[7:0])
        cmd(8'h20);
        cmd(8'h0b);
        get(`VIC_OFF_CMD);
        `VIC_CHK("eos", 8'h00, rdv[7:0])
        dat(8'h20);
        get(`VIC_OFF_DATA);
        `VIC_CHK("mask read", 8'h20, rdv[7:0])
        request_input <= 8'h28;
        repeat (6) @(posedge clk);
        `VIC_CHK("masked irq", 1'b0, irq_out)
        dat(8'h00);
        irq_wait();
        `VIC_CHK("late irq", 1'b1, irq_out)
        host.wr(`VIC_OFF_ACK, 8'h00, resp);
        get(`VIC_OFF_ACK);
        `VIC_CHK("vector 5", 17'h1_12b4, rdv[16:0])
        request_input <= 8'h68;
        repeat (6) @(posedge clk);
        `VIC_CHK("blocked irq", 1'b0, irq_out)
        cmd(8'h68);
        dat(8'h20);
        irq_wait();
        `VIC_CHK("special mask", 1'b1, irq_out)
        cmd(8'h20);
    endtask

    task automatic t_refuse();
        host.wr(8'h10, 8'hff, resp);
        `VIC_CHK("unmapped", 2'h2, resp)
        get(8'h10);
        `VIC_CHK("read resp", 2'h2, s_axi_rresp)
        get(`VIC_OFF_DATA);
        `VIC_CHK("no effect", 8'h20, rdv[7:0])
    endtask

    task automatic test_done();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        rst_n         = 1'b0;
        request_input = 8'h00;
        failures      = 0;
        compares      = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_cascade();
        t_single();
        t_refuse();
        test_done();
    end

    // The whole run needs well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
